// File: core/dio_defines.svh
// register offsets, field positions, reset values and timing figures of the io conditioner
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// register byte offsets
`define DIO_CTRL_OFS        8'h00
`define DIO_INSEL_LO_OFS    8'h04
`define DIO_INSEL_HI_OFS    8'h08
`define DIO_RELAY_SEL_OFS   8'h0c
`define DIO_FREQ_DET_OFS    8'h10
`define DIO_STATUS_OFS      8'h14

// control register fields
`define DIO_CTRL_SCAN_BIT   0
`define DIO_CTRL_POL_LO_LSB 1
`define DIO_CTRL_POL_HI_LSB 5
`define DIO_CTRL_WPROT_BIT  9
`define DIO_CTRL_KEB_LSB    11
`define DIO_CTRL_STOP_LSB   16

// reset values
`define DIO_CTRL_RST        32'h0000_0000
`define DIO_INSEL_RST       32'h0000_0000
`define DIO_RELAY_RST       32'h0000_0000
`define DIO_FREQ_RST        32'h0000_0000

// function codes of the input terminals
`define FN_PID_DISABLE      6'h10
`define FN_JOG              6'h1d
`define FN_RAMP2            6'h1e
`define FN_OVERHEAT         6'h1f
`define FN_DC_BRAKE         6'h21
`define FN_FIRE             6'h2f
`define FN_KINETIC          6'h30
`define FN_WRITE_OK         6'h31
`define FN_START_GUARD      6'h32
`define FN_SECOND_LOOP_CONTROLLER             6'h36
`define FN_FORCED_RUN       6'h39
`define FN_PERMISSIVE       6'h3a

// relay codes 3 to 5 computed here, code 6 passed through from the drive, and reserved codes that never drive a contact
`define RLY_FREQ_AGREE_SET  6
`define RLY_FREQ_ABOVE      4
`define RLY_FREQ_BELOW      5
`define RLY_SET_AGREE       3
`define RLY_RESERVED_MASK   64'hffff_ff9e_f003_cd80

// qualification times
`define CLK_MHZ             100
`define SCAN_SHORT_US       4000
`define SCAN_LONG_US        8000

`endif

// File: core/dio_pkg.sv
// types shared by the io conditioner files
package dio_pkg;

    // decoded drive functions, all levels
    typedef struct packed {
        logic       jog_ref;
        logic       ramp_set2;
        logic       external_overheat_warning;
        logic       dc_brake_en;
        logic       fire_mode;
        logic       kinetic_braking;
        logic       param_write_en;
        logic       unattended_start_guard;
        logic       second_loop_controller;
        logic       forced_freq_run;
        logic       permissive_stop;
        logic [1:0] stop_mode;
    } drive_func_t;

    // drive state feeding the relays and the braking gates
    typedef struct packed {
        logic        run_cmd;
        logic        jog_cmd;
        logic [15:0] out_freq;
        logic [63:0] status_src;
    } drive_state_t;

endpackage

// File: core/drive_digital_io_conditioner.sv
// terminal qualification, function decode and relay selection of the drive
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.svh"

// Operation
// - an input counts only after standing for 4 ms or 8 ms, chosen by one bit
// - four polarity bits for inputs one to four; 1 inverts a normally-closed contact
// - two high polarity bits for inputs five and six, same meaning
// - jog input active selects the jog frequency reference
// - second ramp input active selects second acceleration and deceleration times
// - overheat input shows a warning while active; drive keeps running, no reset
// - dc braking input enables injection braking, inhibited by run or jog
// - fire mode suppresses warnings and protections except short circuit
// - kinetic braking input acts only when its setting is above zero
// - write input gates parameter changes; unassigned, a protection bit decides
// - start guard blocks auto start when run is present at power-up
// - second loop input on selects the second loop controller
// - pid disable plus forced run gives fixed frequency; stops when removed
// - run permissive input requests a stop with the configured stop mode
// - each of three relays drives one status picked by code
// - codes 4 and 5: above and below threshold with hysteresis of width
// - code 3: frequency within threshold plus or minus width
module drive_digital_io_conditioner
    import dio_pkg::*;
#(
    parameter int          NUM_IN    = 6,
    parameter int          CW        = 20,
    parameter logic [19:0] SCAN_SHORT = 20'(`SCAN_SHORT_US * `CLK_MHZ),
    parameter logic [19:0] SCAN_LONG  = 20'(`SCAN_LONG_US * `CLK_MHZ)
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // ahb-lite slave
    input  wire logic              i_hsel,
    input  wire logic [7:0]        i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic [31:0]            o_hrdata,
    output logic                   o_hreadyout,
    output logic                   o_hresp,
    // terminals and drive state
    input  wire logic [NUM_IN-1:0] i_multi_function_inputs,
    input  wire dio_pkg::drive_state_t i_state,
    // decoded functions and relays
    output dio_pkg::drive_func_t   o_func,
    output logic                   o_relay_one_contacts,
    output logic                   o_relay_two_contacts,
    output logic                   o_relay_three_contacts
);
    import dio_pkg::*;

    // ------------------------------------------------------------
    // register file over ahb-lite
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] insel_lo_ff, nxt_insel_lo;
    logic [31:0] insel_hi_ff, nxt_insel_hi;
    logic [31:0] relay_sel_ff, nxt_relay_sel;
    logic [31:0] freq_det_ff, nxt_freq_det;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic        hready_ff, nxt_hready;
    logic        pend_ff, nxt_pend;
    logic        pwr_ff, nxt_pwr;
    logic [7:0]  addr_ff, nxt_addr;
    logic [31:0] status_word;

    // every transfer takes one wait state so a read never races a write
    always_comb begin
        nxt_ctrl      = ctrl_ff;
        nxt_insel_lo  = insel_lo_ff;
        nxt_insel_hi  = insel_hi_ff;
        nxt_relay_sel = relay_sel_ff;
        nxt_freq_det  = freq_det_ff;
        nxt_hrdata    = hrdata_ff;
        nxt_hready    = 1'b1;
        nxt_pend      = 1'b0;
        nxt_pwr       = pwr_ff;
        nxt_addr      = addr_ff;
        if (pend_ff) begin
            if (pwr_ff) begin
                case (addr_ff)
                    `DIO_CTRL_OFS:      nxt_ctrl      = i_hwdata;
                    `DIO_INSEL_LO_OFS:  nxt_insel_lo  = i_hwdata;
                    `DIO_INSEL_HI_OFS:  nxt_insel_hi  = i_hwdata;
                    `DIO_RELAY_SEL_OFS: nxt_relay_sel = i_hwdata;
                    `DIO_FREQ_DET_OFS:  nxt_freq_det  = i_hwdata;
                    default:            nxt_ctrl      = ctrl_ff;
                endcase
            end else begin
                case (addr_ff)
                    `DIO_CTRL_OFS:      nxt_hrdata = ctrl_ff;
                    `DIO_INSEL_LO_OFS:  nxt_hrdata = insel_lo_ff;
                    `DIO_INSEL_HI_OFS:  nxt_hrdata = insel_hi_ff;
                    `DIO_RELAY_SEL_OFS: nxt_hrdata = relay_sel_ff;
                    `DIO_FREQ_DET_OFS:  nxt_hrdata = freq_det_ff;
                    `DIO_STATUS_OFS:    nxt_hrdata = status_word;
                    default:            nxt_hrdata = 32'h0000_0000;
                endcase
            end
        end else if (i_hsel && i_htrans[1] && i_hready) begin
            nxt_pend   = 1'b1;
            nxt_hready = 1'b0;
            nxt_pwr    = i_hwrite;
            nxt_addr   = {i_haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff      <= `DIO_CTRL_RST;
            insel_lo_ff  <= `DIO_INSEL_RST;
            insel_hi_ff  <= `DIO_INSEL_RST;
            relay_sel_ff <= `DIO_RELAY_RST;
            freq_det_ff  <= `DIO_FREQ_RST;
            hrdata_ff    <= 32'h0000_0000;
            hready_ff    <= 1'b1;
            pend_ff      <= 1'b0;
            pwr_ff       <= 1'b0;
            addr_ff      <= 8'h00;
        end else begin
            ctrl_ff      <= nxt_ctrl;
            insel_lo_ff  <= nxt_insel_lo;
            insel_hi_ff  <= nxt_insel_hi;
            relay_sel_ff <= nxt_relay_sel;
            freq_det_ff  <= nxt_freq_det;
            hrdata_ff    <= nxt_hrdata;
            hready_ff    <= nxt_hready;
            pend_ff      <= nxt_pend;
            pwr_ff       <= nxt_pwr;
            addr_ff      <= nxt_addr;
        end
    end

    assign o_hrdata    = hrdata_ff;
    assign o_hreadyout = hready_ff;
    assign o_hresp     = 1'b0;

    // ------------------------------------------------------------
    // polarity and qualification
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] polarity;
    logic [NUM_IN-1:0] pol_level;
    logic [NUM_IN-1:0] qual;
    logic [CW-1:0]     limit;
    logic [5:0]        sel [NUM_IN];
    logic [63:0]       on_acc  [NUM_IN+1];
    logic [63:0]       asg_acc [NUM_IN+1];

    assign polarity = {ctrl_ff[`DIO_CTRL_POL_HI_LSB +: 2],
                       ctrl_ff[`DIO_CTRL_POL_LO_LSB +: 4]};
    assign limit = ctrl_ff[`DIO_CTRL_SCAN_BIT] ? CW'(SCAN_LONG) : CW'(SCAN_SHORT);
    assign on_acc[0]  = 64'h0;
    assign asg_acc[0] = 64'h0;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            // inversion ahead of the qualifier, so a contact flip is filtered too
            assign pol_level[gi] = i_multi_function_inputs[gi] ^ polarity[gi];
            input_qualifier #(.CW(CW)) u_qual (
                .i_mclk  (i_mclk),
                .i_rst_n (i_rst_n),
                .i_level (pol_level[gi]),
                .i_limit (limit),
                .o_level (qual[gi])
            );
            if (gi < 4) begin : g_lo
                assign sel[gi] = insel_lo_ff[gi*6 +: 6];
            end else begin : g_hi
                assign sel[gi] = insel_hi_ff[(gi-4)*6 +: 6];
            end
            assign asg_acc[gi+1] = asg_acc[gi] | (64'h1 << sel[gi]);
            assign on_acc[gi+1]  = on_acc[gi] | ({63'h0, qual[gi]} << sel[gi]);
        end
    endgenerate

    // ------------------------------------------------------------
    // function decode and start guard
    // ------------------------------------------------------------
    logic [63:0] fn_on, fn_asg;
    drive_func_t func_ff, nxt_func;
    logic        boot_ff, nxt_boot;
    logic        guard_ff, nxt_guard;

    assign fn_on  = on_acc[NUM_IN];
    assign fn_asg = asg_acc[NUM_IN];

    // run present at the first edge after reset latches the block until run drops
    always_comb begin
        nxt_boot  = 1'b1;
        nxt_guard = guard_ff;
        if (!boot_ff) begin
            nxt_guard = i_state.run_cmd;
        end else if (!i_state.run_cmd) begin
            nxt_guard = 1'b0;
        end
    end

    always_comb begin
        nxt_func = '0;
        nxt_func.jog_ref   = fn_on[`FN_JOG];
        nxt_func.ramp_set2 = fn_on[`FN_RAMP2];
        nxt_func.external_overheat_warning = fn_on[`FN_OVERHEAT];
        nxt_func.dc_brake_en = fn_on[`FN_DC_BRAKE] &
                               ~i_state.run_cmd & ~i_state.jog_cmd;
        nxt_func.fire_mode = fn_on[`FN_FIRE];
        nxt_func.kinetic_braking = fn_on[`FN_KINETIC] &
                                   (ctrl_ff[`DIO_CTRL_KEB_LSB +: 4] != 4'h0);
        nxt_func.param_write_en = fn_asg[`FN_WRITE_OK] ? fn_on[`FN_WRITE_OK] :
                                  ~ctrl_ff[`DIO_CTRL_WPROT_BIT];
        nxt_func.unattended_start_guard = fn_on[`FN_START_GUARD] & nxt_guard;
        nxt_func.second_loop_controller = fn_on[`FN_SECOND_LOOP_CONTROLLER];
        nxt_func.forced_freq_run = fn_on[`FN_PID_DISABLE] & fn_on[`FN_FORCED_RUN];
        nxt_func.permissive_stop = fn_on[`FN_PERMISSIVE];
        nxt_func.stop_mode = ctrl_ff[`DIO_CTRL_STOP_LSB +: 2];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            func_ff  <= '0;
            boot_ff  <= 1'b0;
            guard_ff <= 1'b0;
        end else begin
            func_ff  <= nxt_func;
            boot_ff  <= nxt_boot;
            guard_ff <= nxt_guard;
        end
    end

    assign o_func = func_ff;

    // ------------------------------------------------------------
    // frequency detection and relays
    // ------------------------------------------------------------
    logic [15:0] thr, wid;
    logic [16:0] f17, hi_lim, lo_lim;
    logic        above_ff, nxt_above;
    logic        below_ff, nxt_below;
    logic [63:0] src;
    logic [2:0]  relay_ff, nxt_relay;

    assign thr    = freq_det_ff[15:0];
    assign wid    = freq_det_ff[31:16];
    assign f17    = {1'b0, i_state.out_freq};
    assign hi_lim = {1'b0, thr} + {1'b0, wid};
    assign lo_lim = (thr > wid) ? {1'b0, thr - wid} : 17'h0;

    // hysteresis: each flag leaves only once the frequency is a width past the threshold
    always_comb begin
        nxt_above = above_ff;
        nxt_below = below_ff;
        if (f17 > {1'b0, thr}) begin
            nxt_above = 1'b1;
        end else if (f17 < lo_lim) begin
            nxt_above = 1'b0;
        end
        if (f17 < {1'b0, thr}) begin
            nxt_below = 1'b1;
        end else if (f17 > hi_lim) begin
            nxt_below = 1'b0;
        end
    end

    always_comb begin
        src = i_state.status_src & ~`RLY_RESERVED_MASK;
        src[`RLY_FREQ_ABOVE] = above_ff;
        src[`RLY_FREQ_BELOW] = below_ff;
        src[`RLY_SET_AGREE]  = (f17 >= lo_lim) && (f17 <= hi_lim);
    end

    genvar gr;
    generate
        for (gr = 0; gr < 3; gr++) begin : g_rly
            assign nxt_relay[gr] = src[relay_sel_ff[gr*6 +: 6]];
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            above_ff <= 1'b0;
            below_ff <= 1'b0;
            relay_ff <= 3'h0;
        end else begin
            above_ff <= nxt_above;
            below_ff <= nxt_below;
            relay_ff <= nxt_relay;
        end
    end

    assign o_relay_one_contacts   = relay_ff[0];
    assign o_relay_two_contacts   = relay_ff[1];
    assign o_relay_three_contacts = relay_ff[2];
    assign status_word = {10'h0, relay_ff, below_ff, above_ff, func_ff[12:2], qual};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_QUAL_FROM_POL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (qual != $past(qual)) |-> ((qual ^ $past(qual)) & ~($past(pol_level) ~^ qual)) == '0)
        else $error("qualified input changed to a level not present");
    AST_JOG_FOLLOWS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (|(qual & {sel[5] == `FN_JOG, sel[4] == `FN_JOG, sel[3] == `FN_JOG,
                   sel[2] == `FN_JOG, sel[1] == `FN_JOG, sel[0] == `FN_JOG}))
        |=> o_func.jog_ref)
        else $error("jog input active but jog reference not selected");
    AST_DC_INHIBIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_state.run_cmd || i_state.jog_cmd) |=> !o_func.dc_brake_en)
        else $error("dc braking enabled during run or jog");
    AST_KEB_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ctrl_ff[`DIO_CTRL_KEB_LSB +: 4] == 4'h0) |=> !o_func.kinetic_braking)
        else $error("kinetic braking active with zero setting");
    AST_WRITE_PROT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !fn_asg[`FN_WRITE_OK] |=> (o_func.param_write_en == !$past(ctrl_ff[`DIO_CTRL_WPROT_BIT])))
        else $error("write enable does not follow protection bit");
    AST_GUARD_BOOT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (guard_ff && !$past(guard_ff)) |-> !$past(boot_ff))
        else $error("start guard latched after power-up");
    AST_FORCED_PAIR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_func.forced_freq_run |-> $past(fn_on[`FN_PID_DISABLE] && fn_on[`FN_FORCED_RUN]))
        else $error("forced run without both inputs");
    AST_ABOVE_HYST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(above_ff) |-> $past(f17 < lo_lim))
        else $error("above flag left inside hysteresis band");
    AST_BELOW_HYST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(below_ff) |-> $past(f17 < {1'b0, thr}))
        else $error("below flag set at or above threshold");
    AST_RELAY_RESERVED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (relay_sel_ff[5:0] == 6'h07) [*2] |-> !o_relay_one_contacts)
        else $error("reserved relay code drove a contact");
    AST_AHB_WAIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_hsel && i_htrans[1] && i_hready && o_hreadyout) |=> !o_hreadyout ##1 o_hreadyout)
        else $error("transfer did not take exactly one wait state");

endmodule

`default_nettype wire

// File: core/input_qualifier.sv
// one terminal scan-time qualifier
`timescale 1ns/10ps
`default_nettype none

module input_qualifier #(
    parameter int CW = 20
) (
    // clock and reset
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    // level and qualification period
    input  wire logic          i_level,
    input  wire logic [CW-1:0] i_limit,
    // qualified level
    output logic               o_level
);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          lvl_ff;
    logic          nxt_lvl;

    // a new level is taken only after it stood unbroken for the whole period
    always_comb begin
        nxt_cnt = '0;
        nxt_lvl = lvl_ff;
        if (i_level != lvl_ff) begin
            if (cnt_ff + 1'b1 >= i_limit) begin
                nxt_lvl = i_level;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
            lvl_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            lvl_ff <= nxt_lvl;
        end
    end

    assign o_level = lvl_ff;

endmodule

`default_nettype wire

// File: dv/field_contacts.sv
// switch and contact wiring in front of the six terminals
`timescale 1ns/10ps
`default_nettype none

module field_contacts (
    // actuation and wiring style per terminal
    input  wire logic [5:0] i_act,
    input  wire logic [5:0] i_nc,
    // levels seen at the terminals
    output logic [5:0]      o_raw
);
    // a normally-closed contact opens when actuated, so the wire drops
    assign o_raw = i_act ^ i_nc;
endmodule

`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the drive io conditioner
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.svh"

module tb;
    import dio_pkg::*;
    typedef struct { logic [31:0] e; logic [31:0] m; string nm; } note_t;
    logic         i_mclk  = 1'b0;
    logic         i_rst_n = 1'b0;
    logic         hsel    = 1'b0;
    logic         hwrite  = 1'b0;
    logic         rd_ph   = 1'b0;
    logic         snap_q  = 1'b0;
    logic [7:0]   haddr   = 8'h00;
    logic [1:0]   htrans  = 2'b00;
    logic [31:0]  hwdata  = 32'h0;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic [5:0]   act     = 6'h00;
    logic [5:0]   nc      = 6'h00;
    logic [5:0]   raw;
    drive_state_t st      = '0;
    drive_func_t  fn;
    logic         r1;
    logic         r2;
    logic         r3;
    int           n_mismatch = 0;
    int           n_tests    = 0;
    logic [31:0]  seed       = 32'h18;
    logic [31:0]  pol;
    logic [31:0]  src;
    note_t        q[$];
    note_t        cur;
    logic [5:0]   codes[9] = '{`FN_JOG, `FN_RAMP2, `FN_OVERHEAT, `FN_DC_BRAKE, `FN_FIRE,
                               `FN_KINETIC, `FN_WRITE_OK, `FN_SECOND_LOOP_CONTROLLER, `FN_PERMISSIVE};
    int           bits[9]  = '{12, 11, 10, 9, 8, 7, 6, 4, 2};
    int           rcode[10] = '{0, 1, 2, 9, 12, 20, 21, 22, 38, 7};
    logic [15:0]  freqs[5] = '{16'h0032, 16'h0069, 16'h0078, 16'h005f, 16'h0050};
    logic [2:0]   fexp[5]  = '{3'h1, 3'h7, 3'h2, 3'h7, 3'h1};

    field_contacts plant (.i_act(act), .i_nc(nc), .o_raw(raw));

    drive_digital_io_conditioner #(.SCAN_SHORT(20'h00008), .SCAN_LONG(20'h00010)) dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_multi_function_inputs(raw), .i_state(st), .o_func(fn),
        .o_relay_one_contacts(r1), .o_relay_two_contacts(r2), .o_relay_three_contacts(r3));

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [31:0] fb(int b);
        return 32'h1 << (b + 3);
    endfunction

    task chk(string nm, logic [31:0] seen, logic [31:0] e, logic [31:0] m);
        n_tests++;
        if ((seen & m) !== (e & m)) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e & m, seen & m);
        end
    endtask

    task report_and_stop();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // output watcher: takes the oldest note when a result shows up
    // ------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (((rd_ph && hreadyout) || snap_q) && q.size() != 0) begin
            cur = q.pop_front();
            chk(cur.nm, rd_ph ? hrdata : {16'h0, fn, r1, r2, r3}, cur.e, cur.m);
        end
        if (rd_ph && hreadyout) begin
            chk("hresp", {31'h0, hresp}, 32'h0, 32'h1);
        end
    end

    task tick(int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // waits until hready is seen high at a rising edge, bounded
    task wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge i_mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task bus(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] m, string nm);
        if (!wr) q.push_back('{d, m, nm});
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph  <= !wr;
        wait_rdy();
        rd_ph  <= 1'b0;
    endtask

    task snap(logic [31:0] e, logic [31:0] m, string nm);
        q.push_back('{e, m, nm});
        snap_q <= 1'b1;
        tick(1);
        snap_q <= 1'b0;
        tick(1);
    endtask

    task wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, 32'h0, "");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        i_rst_n <= 1'b1;
        tick(1);
        snap(fb(6), fb(6), "write_en_default");
        bus(1'b0, `DIO_INSEL_LO_OFS, 32'h0, 32'hffff_ffff, "insel_reset");
        bus(1'b0, 8'h18, 32'h0, 32'hffff_ffff, "unmapped_read");
        wr(`DIO_STATUS_OFS, 32'hffff_ffff);
        bus(1'b0, `DIO_STATUS_OFS, 32'h0, 32'h3f, "status_read_only");
        wr(`DIO_CTRL_OFS, 32'h0000_0200);
        snap(32'h0, fb(6), "write_protect");
        for (int k = 0; k < 9; k++) begin
            pol = rnd();
            nc  <= pol[5:0];
            // polarity goes in before any terminal gets a function
            wr(`DIO_CTRL_OFS, 32'h800 | (32'(k % 4) << 16) | (32'(pol[3:0]) << 1)
                | (32'(pol[5:4]) << 5));
            wr(`DIO_INSEL_LO_OFS, (k % 6 < 4) ? 32'(codes[k]) << (6 * (k % 6)) : 32'h0);
            wr(`DIO_INSEL_HI_OFS, (k % 6 >= 4) ? 32'(codes[k]) << (6 * (k % 6 - 4)) : 32'h0);
            tick(12);
            snap(32'h0, fb(bits[k]), "func_idle");
            act[k % 6] <= 1'b1;
            tick(12);
            snap(fb(bits[k]) | (32'(k % 4) << 3),
                 fb(bits[k]) | 32'h18,
                 "func_on");
            act <= 6'h00;
        end
        nc <= 6'h00;
        wr(`DIO_CTRL_OFS, 32'h0000_0800);
        wr(`DIO_INSEL_HI_OFS, 32'h0);
        wr(`DIO_INSEL_LO_OFS, 32'(`FN_DC_BRAKE));
        act         <= 6'h01;
        st.run_cmd  <= 1'b1;
        tick(12);
        snap(32'h0, fb(9), "dc_brake_inhibit");
        wr(`DIO_INSEL_LO_OFS, 32'(`FN_PID_DISABLE) | (32'(`FN_FORCED_RUN) << 6));
        act <= 6'h03;
        tick(12);
        snap(fb(3), fb(3), "forced_run_on");
        act <= 6'h01;
        tick(12);
        snap(32'h0, fb(3), "forced_run_off");
        wr(`DIO_CTRL_OFS, 32'h0000_0801);
        wr(`DIO_INSEL_LO_OFS, 32'(`FN_JOG));
        act <= 6'h00;
        tick(20);
        act <= 6'h01;
        tick(11);
        snap(32'h0, fb(12), "long_scan_early");
        tick(8);
        snap(fb(12), fb(12), "long_scan_done");
        act <= 6'h00;
        tick(20);
        act <= 6'h01;
        tick(6);
        act <= 6'h00;
        tick(20);
        snap(32'h0, fb(12), "glitch_ignored");
        for (int k = 0; k < 6; k++) begin
            src = rnd();
            st.status_src <= {rnd(), src};
            pol = {rnd()};
            wr(`DIO_RELAY_SEL_OFS, 32'(rcode[pol[3:0] % 10]) | (32'(rcode[pol[7:4] % 10]) << 6)
                | (32'(rcode[pol[11:8] % 10]) << 12));
            tick(3);
            snap({st.status_src[rcode[pol[3:0] % 10]] && rcode[pol[3:0] % 10] != 7,
                  st.status_src[rcode[pol[7:4] % 10]] && rcode[pol[7:4] % 10] != 7,
                  st.status_src[rcode[pol[11:8] % 10]] && rcode[pol[11:8] % 10] != 7},
                 32'h7, "relay_select");
        end
        wr(`DIO_FREQ_DET_OFS, {16'h000a, 16'h0064});
        wr(`DIO_RELAY_SEL_OFS, 32'h3 | (32'h4 << 6) | (32'h5 << 12));
        for (int k = 0; k < 5; k++) begin
            st.out_freq <= freqs[k];
            tick(4);
            snap(32'(fexp[k]), 32'h7, "freq_detect");
        end
        st.run_cmd <= 1'b1;
        i_rst_n    <= 1'b0;
        tick(10);
        i_rst_n <= 1'b1;
        tick(1);
        wr(`DIO_INSEL_LO_OFS, 32'(`FN_START_GUARD));
        act <= 6'h01;
        tick(12);
        snap(fb(5), fb(5), "start_guard_on");
        st.run_cmd <= 1'b0;
        tick(3);
        snap(32'h0, fb(5), "start_guard_clear");
        report_and_stop();
    end

    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

`default_nettype wire
